/* logic/power_state_defs.vh */
`ifndef POWER_STATE_DEFS_VH
`define POWER_STATE_DEFS_VH

// register byte offsets
`define OFS_POWER_STATE_CONTROL   12'h000
`define OFS_DSI_POWER_BLOCK_CTL   12'h004
`define OFS_PROGRAM_CONTROL       12'h008
`define OFS_ENGINE_STATUS         12'h00c
`define OFS_PROGRAM_BASE          12'h100

// power_state_control fields
`define BIT_CLOCK_OFF_ENABLE      0
`define BIT_CLOCK_OFF_STATUS      1
`define BIT_DEEP_OFF_ALLOW        3
`define BIT_DEEP_OFF_STATUS       4

// dsi_power_block_control fields
`define BIT_DSI_BLOCK             0

// program control fields
`define BIT_PROGRAM_LOADED        0

// engine status fields
`define BIT_CORE_PLL_ON           0
`define BIT_DSI_PLL_ON            1
`define BIT_BUF_POWER_ON          2
`define BIT_FITTER_POWER_ON       3
`define BIT_CORE_ON_CRYSTAL       4
`define BIT_ENGINE_POWERED        5
`define BIT_HALF_REFRESH          6

// reset values
`define RST_POWER_STATE_CONTROL   32'h0000_0000
`define RST_PROGRAM_CONTROL       32'h0000_0000

// timing: delay before clock-off entry and length of the deep power-off hold, in cycles
`define ENTRY_SETTLE_CYCLES       8'h10
`define DEEP_OFF_HOLD_CYCLES      8'h40

// axi responses
`define RESP_OKAY                 2'b00
`define RESP_SLVERR               2'b10

`endif

/* logic/half_rate_gate.v */
`timescale 1ns/1ps
`default_nettype none

module half_rate_gate
(
    input  wire         aclk,
    input  wire         aresetn,
    input  wire         enable,
    input  wire         vblank_in,
    input  wire         flip_in,
    output reg          vblank_out,
    output reg          flip_out
);

    reg                 phase_reg;
    reg                 flip_pend_reg;
    wire                pass;

    assign pass = !enable || phase_reg;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            phase_reg     <= 1'b0;
            flip_pend_reg <= 1'b0;
            vblank_out    <= 1'b0;
            flip_out      <= 1'b0;
        end
        else
        begin
            if (vblank_in)
                phase_reg <= !phase_reg;
            vblank_out <= vblank_in && pass; // R18
            // with half refresh enabled, flips wait for the next forwarded vblank; otherwise they pass straight through
            if (!enable)
            begin
                flip_out      <= flip_in;
                flip_pend_reg <= 1'b0;
            end
            else
            begin
                flip_out      <= vblank_in && pass && (flip_pend_reg || flip_in); // R18
                if (vblank_in && pass)
                    flip_pend_reg <= 1'b0;
                else if (flip_in)
                    flip_pend_reg <= 1'b1;
            end
        end
    end

endmodule // half_rate_gate

`default_nettype wire

/* logic/context_program_store.v */
`timescale 1ns/1ps
`default_nettype none

module context_program_store
#(
    parameter DEPTH_LOG2 = 6
)
(
    input  wire                  aclk,
    input  wire                  aresetn,
    input  wire                  clear,
    input  wire                  wr_en,
    input  wire [DEPTH_LOG2-1:0] wr_index,
    input  wire [31:0]           wr_data,
    input  wire [DEPTH_LOG2-1:0] rd_index,
    output reg  [31:0]           rd_data,
    output reg                   written
);

    reg [31:0] mem [0:(1<<DEPTH_LOG2)-1];

    always @(posedge aclk)
    begin
        if (wr_en)
            mem[wr_index] <= wr_data;
        rd_data <= mem[rd_index];
    end

    // contents are not wiped; the written flag tells whether storage is valid
    always @(posedge aclk)
    begin
        if (!aresetn || clear)
            written <= 1'b0; // R4
        else if (wr_en)
            written <= 1'b1;
    end

endmodule // context_program_store

`default_nettype wire

/* logic/display_clock_off_power_states.v */
// Chosen here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "power_state_defs.vh"

// Functional notes
// R1 - enter clock-off only permitted and DSI idle
// R2 - leave clock-off on withdrawal or DSI activity
// R3 - core clock falls to crystal when off
// R4 - program cleared by deep-off and resets
// R5 - software idles audio, transcoders first
// R6 - tearing indication on dedicated wire
// R7 - backlight not from utility pin
// R8 - withdraw permission around mode set
// R9 - load program then set enable
// R10 - clear status, disable, wait, poll
// R11 - block indication zero after exit done
// R12 - sticky flag records clock-off reached
// R13 - deep power-off allow sequence by software
// R14 - device cycles power itself when allowed
// R15 - device preserves config registers across off
// R16 - withdraw deep-off then reinitialize, restore
// R17 - writeback disable order kept by software
// R18 - half-rate vblanks, flips aligned
// R19 - half refresh entry order by software
// R20 - half refresh exit order by software
module display_clock_off_power_states
#(
    parameter NUM_DSI    = 2,
    parameter PROG_LOG2  = 6
)
(
    input  wire               aclk,
    input  wire               aresetn,
    input  wire [11:0]        s_axi_awaddr,
    input  wire               s_axi_awvalid,
    output wire               s_axi_awready,
    input  wire [31:0]        s_axi_wdata,
    input  wire [3:0]         s_axi_wstrb,
    input  wire               s_axi_wvalid,
    output wire               s_axi_wready,
    output reg  [1:0]         s_axi_bresp,
    output reg                s_axi_bvalid,
    input  wire               s_axi_bready,
    input  wire [11:0]        s_axi_araddr,
    input  wire               s_axi_arvalid,
    output wire               s_axi_arready,
    output reg  [31:0]        s_axi_rdata,
    output reg  [1:0]         s_axi_rresp,
    output reg                s_axi_rvalid,
    input  wire               s_axi_rready,
    input  wire [NUM_DSI-1:0] dsi_active,
    input  wire               platform_reset_event,
    input  wire               half_refresh_enable,
    input  wire               vblank_in,
    input  wire               flip_in,
    output wire               vertical_blank_interrupt,
    output wire               flip_done,
    output reg                core_pll_on,
    output reg                dsi_pll_on,
    output reg                buf_power_on,
    output reg                fitter_power_on,
    output reg                core_clk_from_crystal,
    output reg                engine_powered,
    output reg                config_retain
);

    // ----------------------------------------
    // states
    // ----------------------------------------
    localparam [2:0] ST_ACTIVE   = 3'd0;
    localparam [2:0] ST_SETTLE   = 3'd1;
    localparam [2:0] ST_CLK_OFF  = 3'd2;
    localparam [2:0] ST_DEEP_OFF = 3'd3;
    localparam [2:0] ST_DEEP_ON  = 3'd4;

    reg  [2:0]  state_reg;
    reg  [7:0]  count_reg;
    reg         clk_off_en_reg;
    reg         clk_off_status_reg;
    reg         deep_allow_reg;
    reg         deep_status_reg;
    reg         dsi_block_reg;

    wire        program_loaded;
    wire        dsi_busy;
    wire        permitted;
    wire        program_clear;

    assign dsi_busy  = |dsi_active;
    assign permitted = clk_off_en_reg && program_loaded && !deep_allow_reg;

    // ----------------------------------------
    // axi4-lite slave
    // ----------------------------------------
    reg         rd_pend_reg;
    reg         aw_hold_reg;
    reg  [11:0] aw_addr_reg;
    reg         w_hold_reg;
    reg  [31:0] w_data_reg;
    reg  [3:0]  w_strb_reg;
    wire        wr_fire;

    assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_hold_reg && !s_axi_bvalid;
    // no address taken while one is pending, else it would be lost
    assign s_axi_arready = !s_axi_rvalid && !rd_pend_reg;
    assign wr_fire       = aw_hold_reg && w_hold_reg && !s_axi_bvalid;

    function is_prog_addr;
        input [11:0] a;
        begin
            is_prog_addr = (a >= `OFS_PROGRAM_BASE)
                && (a < `OFS_PROGRAM_BASE + (12'h004 << PROG_LOG2));
        end
    endfunction

    function [PROG_LOG2-1:0] prog_index;
        input [11:0] a;
        reg   [11:0] d;
        begin
            d          = a - `OFS_PROGRAM_BASE;
            prog_index = d[PROG_LOG2+1:2];
        end
    endfunction

    wire        wr_ctrl = wr_fire && w_strb_reg[0]
                          && aw_addr_reg == `OFS_POWER_STATE_CONTROL;
    wire        wr_prog = wr_fire && (&w_strb_reg) && is_prog_addr(aw_addr_reg);
    wire [31:0] prog_rd;

    assign program_clear = deep_status_reg || platform_reset_event; // R4

    context_program_store #(
        .DEPTH_LOG2 (PROG_LOG2)
    ) u_store (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .clear    (program_clear),
        .wr_en    (wr_prog),
        .wr_index (prog_index(aw_addr_reg)),
        .wr_data  (w_data_reg),
        .rd_index (prog_index(s_axi_araddr)),
        .rd_data  (prog_rd),
        .written  (program_loaded)
    );

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_reg  <= 1'b0;
            aw_addr_reg  <= 12'h000;
            w_hold_reg   <= 1'b0;
            w_data_reg   <= 32'h0000_0000;
            w_strb_reg   <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_hold_reg  <= 1'b0;
                w_hold_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr_reg == `OFS_POWER_STATE_CONTROL
                                 || aw_addr_reg == `OFS_DSI_POWER_BLOCK_CTL
                                 || aw_addr_reg == `OFS_PROGRAM_CONTROL
                                 || aw_addr_reg == `OFS_ENGINE_STATUS
                                 || is_prog_addr(aw_addr_reg))
                                ? `RESP_OKAY : `RESP_SLVERR;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // ----------------------------------------
    // read path; program words read one cycle late via store
    // ----------------------------------------
    reg  [11:0] rd_addr_reg;
    reg  [31:0] rd_word;
    reg         rd_ok;

    always @*
    begin
        rd_word = 32'h0000_0000;
        rd_ok   = 1'b1;
        case (rd_addr_reg)
            `OFS_POWER_STATE_CONTROL:
            begin
                rd_word[`BIT_CLOCK_OFF_ENABLE] = clk_off_en_reg;
                rd_word[`BIT_CLOCK_OFF_STATUS] = clk_off_status_reg;
                rd_word[`BIT_DEEP_OFF_ALLOW]   = deep_allow_reg;
                rd_word[`BIT_DEEP_OFF_STATUS]  = deep_status_reg;
            end
            `OFS_DSI_POWER_BLOCK_CTL: rd_word[`BIT_DSI_BLOCK] = dsi_block_reg;
            `OFS_PROGRAM_CONTROL: rd_word[`BIT_PROGRAM_LOADED] = program_loaded;
            `OFS_ENGINE_STATUS:
            begin
                rd_word[`BIT_CORE_PLL_ON]     = core_pll_on;
                rd_word[`BIT_DSI_PLL_ON]      = dsi_pll_on;
                rd_word[`BIT_BUF_POWER_ON]    = buf_power_on;
                rd_word[`BIT_FITTER_POWER_ON] = fitter_power_on;
                rd_word[`BIT_CORE_ON_CRYSTAL] = core_clk_from_crystal;
                rd_word[`BIT_ENGINE_POWERED]  = engine_powered;
                rd_word[`BIT_HALF_REFRESH]    = half_refresh_enable;
            end
            default:
            begin
                if (is_prog_addr(rd_addr_reg))
                    rd_word = prog_rd;
                else
                    rd_ok = 1'b0;
            end
        endcase
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rd_pend_reg  <= 1'b0;
            rd_addr_reg  <= 12'h000;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `RESP_OKAY;
        end
        else
        begin
            if (s_axi_arvalid && s_axi_arready && !rd_pend_reg)
            begin
                rd_pend_reg <= 1'b1;
                rd_addr_reg <= s_axi_araddr;
            end
            else if (rd_pend_reg)
            begin
                rd_pend_reg  <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------
    // control bits
    // ----------------------------------------
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            clk_off_en_reg     <= 1'b0;
            deep_allow_reg     <= 1'b0;
            clk_off_status_reg <= 1'b0;
        end
        else
        begin
            if (wr_ctrl)
            begin
                clk_off_en_reg <= w_data_reg[`BIT_CLOCK_OFF_ENABLE];
                deep_allow_reg <= w_data_reg[`BIT_DEEP_OFF_ALLOW];
            end
            // entry sets, write-one clears; set wins
            if (state_reg == ST_CLK_OFF)
                clk_off_status_reg <= 1'b1; // R12
            else if (wr_ctrl && w_data_reg[`BIT_CLOCK_OFF_STATUS])
                clk_off_status_reg <= 1'b0; // R12
        end
    end

    // ----------------------------------------
    // power state machine
    // ----------------------------------------
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_reg       <= ST_ACTIVE;
            count_reg       <= 8'h00;
            dsi_block_reg   <= 1'b0;
            deep_status_reg <= 1'b0;
        end
        else
        begin
            case (state_reg)
                ST_ACTIVE:
                begin
                    count_reg     <= 8'h00;
                    dsi_block_reg <= 1'b0; // R11
                    if (deep_allow_reg)
                        state_reg <= ST_DEEP_OFF; // R14
                    else if (permitted && !dsi_busy)
                    begin
                        state_reg     <= ST_SETTLE;
                        dsi_block_reg <= 1'b1;
                    end
                end
                ST_SETTLE:
                begin
                    // idle must persist before gating
                    if (!permitted || dsi_busy)
                        state_reg <= ST_ACTIVE; // R2
                    else if (count_reg == `ENTRY_SETTLE_CYCLES)
                        state_reg <= ST_CLK_OFF; // R1
                    else
                        count_reg <= count_reg + 8'h01;
                end
                ST_CLK_OFF:
                begin
                    if (!permitted || dsi_busy)
                        state_reg <= ST_ACTIVE; // R2
                end
                ST_DEEP_OFF:
                begin
                    deep_status_reg <= 1'b1;
                    if (count_reg == `DEEP_OFF_HOLD_CYCLES)
                    begin
                        state_reg <= ST_DEEP_ON;
                        count_reg <= 8'h00;
                    end
                    else
                        count_reg <= count_reg + 8'h01;
                end
                ST_DEEP_ON:
                begin
                    deep_status_reg <= 1'b0;
                    // stays powered here without redoing the cycle until allow is withdrawn
                    if (!deep_allow_reg)
                        state_reg <= ST_ACTIVE; // R14
                end
                default: state_reg <= ST_ACTIVE;
            endcase
        end
    end

    // ----------------------------------------
    // power and clock outputs
    // ----------------------------------------
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            core_pll_on           <= 1'b1;
            dsi_pll_on            <= 1'b1;
            buf_power_on          <= 1'b1;
            fitter_power_on       <= 1'b1;
            core_clk_from_crystal <= 1'b0;
            engine_powered        <= 1'b1;
            config_retain         <= 1'b0;
        end
        else
        begin
            core_pll_on     <= !(state_reg == ST_CLK_OFF || state_reg == ST_DEEP_OFF); // R1
            dsi_pll_on      <= state_reg != ST_CLK_OFF; // R1
            buf_power_on    <= state_reg != ST_CLK_OFF; // R1
            fitter_power_on <= state_reg != ST_CLK_OFF; // R1
            core_clk_from_crystal <= state_reg == ST_CLK_OFF; // R3
            engine_powered  <= state_reg != ST_DEEP_OFF; // R14
            config_retain   <= state_reg == ST_DEEP_OFF; // R15
        end
    end

    half_rate_gate u_gate (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .enable     (half_refresh_enable),
        .vblank_in  (vblank_in),
        .flip_in    (flip_in),
        .vblank_out (vertical_blank_interrupt),
        .flip_out   (flip_done)
    );

endmodule // display_clock_off_power_states

`default_nettype wire

/* tb/power_states_props.sv */
`timescale 1ns/1ps
`default_nettype none

module power_states_props
#(
    parameter NUM_DSI   = 2,
    parameter PROG_LOG2 = 6
)
(
    input wire logic               aclk,
    input wire logic               aresetn,
    input wire logic               s_axi_awvalid,
    input wire logic               s_axi_awready,
    input wire logic               s_axi_wvalid,
    input wire logic               s_axi_wready,
    input wire logic               s_axi_bvalid,
    input wire logic               s_axi_arvalid,
    input wire logic               s_axi_arready,
    input wire logic               s_axi_rvalid,
    input wire logic [NUM_DSI-1:0] dsi_active,
    input wire logic               vblank_in,
    input wire logic               half_refresh_enable,
    input wire logic               vertical_blank_interrupt,
    input wire logic               flip_done,
    input wire logic               core_pll_on,
    input wire logic               dsi_pll_on,
    input wire logic               buf_power_on,
    input wire logic               fitter_power_on,
    input wire logic               core_clk_from_crystal,
    input wire logic               engine_powered,
    input wire logic               config_retain
);
    // ------------------------------------------------------------
    // helper logic
    // ------------------------------------------------------------
    // counts idle cycles of all dsi transcoders, saturating
    logic [7:0] idle_reg;

    always @(posedge aclk)
    begin
        if (!aresetn || dsi_active != '0)
            idle_reg <= 8'h00;
        else if (idle_reg != 8'hff)
            idle_reg <= idle_reg + 8'h01;
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence

    sequence s_deep_hold;
        (!engine_powered && config_retain) [*8];
    endsequence

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    AST_ENTRY_IDLE: assert property ($fell(core_pll_on) |-> idle_reg >= 8'h10)
        else $error("clock-off entered without settled idle");
    AST_GATE_GROUP: assert property (engine_powered |->
        {dsi_pll_on, buf_power_on, fitter_power_on} == {3{core_pll_on}})
        else $error("gated outputs disagree");
    AST_CRYSTAL: assert property (engine_powered |-> core_clk_from_crystal == !core_pll_on)
        else $error("core clock source wrong");
    AST_EXIT_DSI: assert property (!core_pll_on && engine_powered && dsi_active != '0
        |-> ##[1:3] core_pll_on)
        else $error("clock-off not left on dsi activity");
    AST_VBI_CAUSE: assert property (vertical_blank_interrupt |-> $past(vblank_in))
        else $error("vblank interrupt without vblank");
    AST_FLIP_ALIGN: assert property ($past(half_refresh_enable) && flip_done
        |-> vertical_blank_interrupt)
        else $error("flip done out of phase");
    AST_WRITE_ANSWER: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
        else $error("write response late");
    AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
        else $error("read response late");
    AST_B_BLOCKS: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    AST_R_BLOCKS: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
    AST_DEEP_HOLD: assert property ($fell(engine_powered) |-> s_deep_hold)
        else $error("deep power-off hold broken");

endmodule // power_states_props

bind display_clock_off_power_states power_states_props
    #(.NUM_DSI(NUM_DSI), .PROG_LOG2(PROG_LOG2)) u_props (.*);

`default_nettype wire

/* tb/display_clock_off_power_states_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "power_state_defs.vh"

module display_clock_off_power_states_tb;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [1:0]  dsi_active = 2'b00;
    logic        platform_reset_event = 1'b0, half_refresh_enable = 1'b0;
    logic        vblank_in = 1'b0, flip_in = 1'b0;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    wire         vertical_blank_interrupt, flip_done, core_pll_on, dsi_pll_on;
    wire         buf_power_on, fitter_power_on, core_clk_from_crystal;
    wire         engine_powered, config_retain;
    int          err_count = 0, num_checks = 0, cyc = 0, vbi_cnt = 0, flip_cnt = 0;
    logic [31:0] d;

    always #25 aclk = ~aclk;

    display_clock_off_power_states #(.NUM_DSI(2), .PROG_LOG2(6)) u_display_clock_off_power_states
        (.*);

    // ------------------------------------------------------------
    // checking and closing
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // cut a hang short; the full run needs a few hundred cycles
    always @(posedge aclk)
    begin
        cyc++;
        if (vertical_blank_interrupt === 1'b1)
            vbi_cnt++;
        if (flip_done === 1'b1)
            flip_cnt++;
        if (cyc == 20000)
        begin
            err_count++;
            test_done();
        end
    end

    // ------------------------------------------------------------
    // bus tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [11:0] a, input logic [31:0] dat, input logic [1:0] er);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= dat;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!done)
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1)
            begin
                done = 1'b1;
                s_axi_bready <= 1'b0;
                chk(32'(s_axi_bresp), 32'(er));
            end
        end
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!done)
        begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1)
            begin
                done = 1'b1;
                d = s_axi_rdata;
                s_axi_rready <= 1'b0;
                chk(32'(s_axi_rresp), 32'(er));
                if (er == `RESP_OKAY)
                    chk(d, e);
            end
        end
    endtask

    task automatic pulse(input logic f);
        @(posedge aclk);
        vblank_in <= 1'b1;
        flip_in <= f;
        @(posedge aclk);
        vblank_in <= 1'b0;
        flip_in <= 1'b0;
        repeat (4) @(posedge aclk);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`OFS_POWER_STATE_CONTROL, 32'h0, `RESP_OKAY);
        rd(`OFS_ENGINE_STATUS, 32'h2f, `RESP_OKAY);
        wr(12'h010, 32'h1, `RESP_SLVERR);
        rd(12'h020, 32'h0, `RESP_SLVERR);
        // tearing, backlight, writeback order kept outside
        // enable with no program and a busy dsi, then load a program with dsi still busy: clocks must stay up
        dsi_active <= 2'b01;
        wr(`OFS_POWER_STATE_CONTROL, 32'h1, `RESP_OKAY);
        repeat (40) @(posedge aclk);
        chk(32'(core_pll_on), 32'h1);
        wr(`OFS_PROGRAM_BASE + 12'h004, 32'h5a5a_0f0f, `RESP_OKAY);
        rd(`OFS_PROGRAM_BASE + 12'h004, 32'h5a5a_0f0f, `RESP_OKAY);
        rd(`OFS_PROGRAM_CONTROL, 32'h1, `RESP_OKAY);
        repeat (40) @(posedge aclk);
        chk(32'(core_pll_on), 32'h1);
        dsi_active <= 2'b00;
        repeat (40) @(posedge aclk);
        chk(32'({core_pll_on, dsi_pll_on, buf_power_on, fitter_power_on}), 32'h0);
        rd(`OFS_ENGINE_STATUS, 32'h30, `RESP_OKAY);
        rd(`OFS_POWER_STATE_CONTROL, 32'h3, `RESP_OKAY);
        rd(`OFS_DSI_POWER_BLOCK_CTL, 32'h1, `RESP_OKAY);
        dsi_active <= 2'b10;
        repeat (3) @(posedge aclk);
        chk(32'(core_pll_on), 32'h1);
        rd(`OFS_POWER_STATE_CONTROL, 32'h3, `RESP_OKAY);
        dsi_active <= 2'b00;
        repeat (40) @(posedge aclk);
        chk(32'(core_pll_on), 32'h0);
        // withdraw: clear status, disable, then poll the block indication
        wr(`OFS_POWER_STATE_CONTROL, 32'h3, `RESP_OKAY);
        wr(`OFS_POWER_STATE_CONTROL, 32'h0, `RESP_OKAY);
        repeat (20) @(posedge aclk);
        chk(32'({core_pll_on, core_clk_from_crystal}), 32'h2);
        rd(`OFS_DSI_POWER_BLOCK_CTL, 32'h0, `RESP_OKAY);
        wr(`OFS_POWER_STATE_CONTROL, 32'h2, `RESP_OKAY);
        rd(`OFS_POWER_STATE_CONTROL, 32'h0, `RESP_OKAY);
        // deep power-off cycle clears the program
        wr(`OFS_POWER_STATE_CONTROL, 32'h8, `RESP_OKAY);
        repeat (3) @(posedge aclk);
        chk(32'({engine_powered, config_retain}), 32'h1);
        repeat (100) @(posedge aclk);
        chk(32'(engine_powered), 32'h1);
        rd(`OFS_PROGRAM_CONTROL, 32'h0, `RESP_OKAY);
        wr(`OFS_POWER_STATE_CONTROL, 32'h0, `RESP_OKAY);
        wr(`OFS_PROGRAM_BASE, 32'h1, `RESP_OKAY);
        @(posedge aclk);
        platform_reset_event <= 1'b1;
        @(posedge aclk);
        platform_reset_event <= 1'b0;
        rd(`OFS_PROGRAM_CONTROL, 32'h0, `RESP_OKAY);
        // half refresh: full rate first, then every other vblank
        pulse(1'b0);
        pulse(1'b0);
        chk(32'(vbi_cnt), 32'h2);
        half_refresh_enable <= 1'b1;
        rd(`OFS_ENGINE_STATUS, 32'h6f, `RESP_OKAY);
        repeat (4) pulse(1'b1);
        chk(32'(vbi_cnt), 32'h4);
        chk(32'(flip_cnt), 32'h2);
        half_refresh_enable <= 1'b0;
        aresetn <= 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`OFS_POWER_STATE_CONTROL, 32'h0, `RESP_OKAY);
        test_done();
    end

endmodule // display_clock_off_power_states_tb

`default_nettype wire
